// file: core/eprg_defs.svh
// Timing counts and limits for the word programmer
`ifndef EPRG_DEFS_SVH
`define EPRG_DEFS_SVH
`define EPRG_CLK_NS 50
`define EPRG_PULSE_NS 100000
`define EPRG_PULSE_MIN_NS 95000
`define EPRG_PULSE_MAX_NS 105000
`define EPRG_PULSE_CYC (`EPRG_PULSE_NS / `EPRG_CLK_NS)
`define EPRG_SETUP_NS 2000
`define EPRG_SETUP_CYC ((`EPRG_SETUP_NS + `EPRG_CLK_NS - 1) / `EPRG_CLK_NS)
`define EPRG_OE_VALID_NS 150
`define EPRG_OE_VALID_CYC ((`EPRG_OE_VALID_NS + `EPRG_CLK_NS - 1) / `EPRG_CLK_NS)
`define EPRG_RELEASE_NS 130
`define EPRG_RELEASE_CYC ((`EPRG_RELEASE_NS + `EPRG_CLK_NS - 1) / `EPRG_CLK_NS)
`define EPRG_MAX_RETRY 4'ha
`define EPRG_LAST_ADDR 16'hffff
`define EPRG_FIFO_DEPTH 16
`endif

// file: core/eprg_pkg.sv
// Types for the word programmer
package eprg_pkg;
	typedef logic [15:0] eprg_word_t;
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_POWER = 10'h002,
		ST_SETUP = 10'h004,
		ST_PULSE = 10'h008,
		ST_HOLD = 10'h010,
		ST_OE = 10'h020,
		ST_CHECK = 10'h040,
		ST_RELEASE = 10'h080,
		ST_DONE = 10'h100,
		ST_FAIL = 10'h200
	} eprg_state_e;
	typedef enum logic [1:0] {
		PH_FIRST = 2'h0,
		PH_LOOP = 2'h1,
		PH_FINAL = 2'h2
	} eprg_phase_e;
endpackage : eprg_pkg

// file: core/eprg_fifo.sv
// Source word FIFO with valid and ready on both sides
module eprg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	// Pointer and count update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage, one entry per slot
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk_sys) begin
			if (push && wr_ff == AW'(i)) begin
				mem_ff[i] <= in_data;
			end
		end
	end

	assign in_ready = cnt_ff != (AW+1)'(DEPTH);
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rd_ff];
endmodule : eprg_fifo

// file: core/eprg_host.sv
// Program-and-verify sequencer for a 64K x 16 UV erasable memory
// What this block does
// - Strobe pulses last 100 us within limits
// - Start at address zero, raise both supplies
// - First pass: one pulse per word, no verify
// - Then verify-and-reprogram loop over every address
// - Mismatch: single pulses, verify each, ten max
// - Still failing after ten: stop, report fail
// - Verified word advances to next address
// - Normal supplies, read all, compare, report
// - Wait for data valid and output release
// - Core supply on first, off with or after the programming supply
// - Identity read: elevated line, others low
module eprg_host
	import eprg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Command and status
	input wire logic start,
	input wire logic id_read,
	output logic busy,
	output logic done,
	output logic pass,
	output logic [15:0] id_code,
	// Source words, one per address in order
	input wire logic src_valid,
	output logic src_ready,
	input wire logic [15:0] src_data,
	// Device pins
	output logic [15:0] addr,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic [15:0] data_in,
	output logic chip_enable_n,
	output logic output_enable_n,
	output logic program_strobe_n,
	output logic vcc_prog,
	output logic vpp_prog,
	output logic id_mode_address_line
);
`include "eprg_defs.svh"
	localparam logic [12:0] PULSE_CYC = 13'(`EPRG_PULSE_CYC);
	localparam logic [12:0] SETUP_CYC = 13'(`EPRG_SETUP_CYC);
	localparam logic [12:0] OE_CYC = 13'(`EPRG_OE_VALID_CYC);
	localparam logic [12:0] REL_CYC = 13'(`EPRG_RELEASE_CYC);
	localparam logic [12:0] PULSE_MIN_CYC = 13'(`EPRG_PULSE_MIN_NS / `EPRG_CLK_NS);
	localparam logic [12:0] PULSE_MAX_CYC = 13'(`EPRG_PULSE_MAX_NS / `EPRG_CLK_NS);

	////////////////////////////////////////////////////////////////////////////
	// Source FIFO and pin synchroniser

	logic fifo_valid, fifo_pop;
	eprg_word_t fifo_data;
	eprg_fifo #(.WIDTH(16), .DEPTH(`EPRG_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.in_data(src_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	eprg_word_t din_s1_ff, din_s2_ff;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			din_s1_ff <= '0;
			din_s2_ff <= '0;
		end else begin
			din_s1_ff <= data_in;
			din_s2_ff <= din_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state

	eprg_state_e st_ff, nxt_st;
	eprg_phase_e ph_ff, nxt_ph;
	logic [12:0] tmr_ff, nxt_tmr;
	logic [3:0] try_ff, nxt_try;
	eprg_word_t addr_ff, nxt_addr, dat_ff, nxt_dat, id_ff, nxt_id;
	logic id_mode_ff, nxt_id_mode;
	logic done_ff, nxt_done, pass_ff, nxt_pass, busy_ff, nxt_busy;
	logic ce_ff, nxt_ce, oe_ff, nxt_oe, pgm_ff, nxt_pgm, doe_ff, nxt_doe;
	logic vcc_ff, nxt_vcc, vpp_ff, nxt_vpp;
	logic last, vfy_first;

	assign last = addr_ff == `EPRG_LAST_ADDR;
	// Loop words are read before any extra pulse, final words are only read
	assign vfy_first = ph_ff == PH_FINAL || (ph_ff == PH_LOOP && try_ff == 4'h0);

	// Next state, timing and pin levels
	always_comb begin
		nxt_st = st_ff;
		nxt_ph = ph_ff;
		nxt_tmr = tmr_ff + 13'h1;
		nxt_try = try_ff;
		nxt_addr = addr_ff;
		nxt_dat = dat_ff;
		nxt_id = id_ff;
		nxt_id_mode = id_mode_ff;
		nxt_done = 1'b0;
		nxt_pass = pass_ff;
		nxt_busy = busy_ff;
		nxt_ce = ce_ff;
		nxt_oe = oe_ff;
		nxt_pgm = 1'b1;
		nxt_doe = doe_ff;
		nxt_vcc = vcc_ff;
		nxt_vpp = vpp_ff;
		fifo_pop = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				nxt_tmr = '0;
				if (id_read) begin
					nxt_id_mode = 1'b1;
					nxt_addr = '0;
					nxt_busy = 1'b1;
					nxt_st = ST_POWER;
				end else if (start && fifo_valid) begin
					nxt_addr = '0;
					nxt_ph = PH_FIRST;
					nxt_busy = 1'b1;
					nxt_pass = 1'b0;
					nxt_vcc = 1'b1;
					nxt_st = ST_POWER;
				end
			end
			ST_POWER: begin
				// Core supply leads the programming supply by a setup time
				if (id_mode_ff) begin
					if (tmr_ff >= SETUP_CYC) begin
						nxt_ce = 1'b0;
						nxt_oe = 1'b0;
						nxt_tmr = '0;
						nxt_st = ST_OE;
					end
				end else if (tmr_ff >= SETUP_CYC) begin
					nxt_vpp = 1'b1;
					nxt_tmr = '0;
					nxt_st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address, data and enables settle before the strobe or the read
				nxt_ce = 1'b0;
				nxt_oe = 1'b1;
				nxt_dat = fifo_data;
				// Drive the lines only once the device has let go of them
				nxt_doe = !vfy_first && tmr_ff >= REL_CYC;
				if (!fifo_valid) begin
					// Source word not here yet: restart the setup time
					nxt_tmr = '0;
				end else if (tmr_ff >= SETUP_CYC + REL_CYC) begin
					nxt_tmr = '0;
					if (vfy_first) begin
						nxt_oe = 1'b0;
						nxt_doe = 1'b0;
						nxt_st = ST_OE;
					end else begin
						nxt_pgm = 1'b0;
						nxt_st = ST_PULSE;
					end
				end
			end
			ST_PULSE: begin
				nxt_pgm = 1'b0;
				if (tmr_ff >= PULSE_CYC - 13'h1) begin
					nxt_pgm = 1'b1;
					nxt_tmr = '0;
					nxt_st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Data hold after the strobe rises
				if (tmr_ff >= SETUP_CYC) begin
					nxt_tmr = '0;
					if (ph_ff == PH_FIRST) begin
						fifo_pop = 1'b1;
						nxt_addr = addr_ff + 16'h1;
						nxt_st = ST_SETUP;
						if (last) begin
							nxt_ph = PH_LOOP;
						end
					end else begin
						nxt_doe = 1'b0;
						nxt_st = ST_RELEASE;
					end
				end
			end
			ST_RELEASE: begin
				// Bus free before the device drives it
				if (tmr_ff >= REL_CYC) begin
					nxt_oe = 1'b0;
					nxt_tmr = '0;
					nxt_st = ST_OE;
				end
			end
			ST_OE: begin
				if (tmr_ff >= OE_CYC) begin
					nxt_tmr = '0;
					nxt_st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				nxt_oe = 1'b1;
				nxt_tmr = '0;
				if (id_mode_ff) begin
					nxt_id = din_s2_ff;
					if (!addr_ff[0]) begin
						nxt_addr = 16'h1;
						nxt_oe = 1'b0;
						nxt_st = ST_OE;
					end else begin
						nxt_st = ST_DONE;
					end
				end else if (din_s2_ff == dat_ff) begin
					nxt_try = '0;
					nxt_addr = addr_ff + 16'h1;
					fifo_pop = 1'b1;
					if (!last) begin
						nxt_st = ST_SETUP;
					end else if (ph_ff == PH_LOOP) begin
						nxt_ph = PH_FINAL;
						nxt_vpp = 1'b0;
						nxt_vcc = 1'b0;
						nxt_st = ST_SETUP;
					end else begin
						nxt_pass = 1'b1;
						nxt_st = ST_DONE;
					end
				end else if (ph_ff == PH_FINAL || try_ff == `EPRG_MAX_RETRY) begin
					nxt_st = ST_FAIL;
				end else begin
					nxt_try = try_ff + 4'h1;
					nxt_st = ST_SETUP;
				end
			end
			ST_DONE, ST_FAIL: begin
				// Programming supply drops before core supply
				nxt_vpp = 1'b0;
				nxt_ce = 1'b1;
				nxt_oe = 1'b1;
				nxt_doe = 1'b0;
				if (tmr_ff >= SETUP_CYC) begin
					nxt_vcc = 1'b0;
					nxt_id_mode = 1'b0;
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
					nxt_st = ST_IDLE;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= ST_IDLE;
			ph_ff <= PH_FIRST;
			tmr_ff <= '0;
			try_ff <= '0;
			addr_ff <= '0;
			dat_ff <= '0;
			id_ff <= '0;
			id_mode_ff <= 1'b0;
			done_ff <= 1'b0;
			pass_ff <= 1'b0;
			busy_ff <= 1'b0;
			ce_ff <= 1'b1;
			oe_ff <= 1'b1;
			pgm_ff <= 1'b1;
			doe_ff <= 1'b0;
			vcc_ff <= 1'b0;
			vpp_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			tmr_ff <= nxt_tmr;
			try_ff <= nxt_try;
			addr_ff <= nxt_addr;
			dat_ff <= nxt_dat;
			id_ff <= nxt_id;
			id_mode_ff <= nxt_id_mode;
			done_ff <= nxt_done;
			pass_ff <= nxt_pass;
			busy_ff <= nxt_busy;
			ce_ff <= nxt_ce;
			oe_ff <= nxt_oe;
			pgm_ff <= nxt_pgm;
			doe_ff <= nxt_doe;
			vcc_ff <= nxt_vcc;
			vpp_ff <= nxt_vpp;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
	assign pass = pass_ff;
	assign id_code = id_ff;
	assign addr = addr_ff;
	assign data_out = dat_ff;
	assign data_oe = doe_ff;
	assign chip_enable_n = ce_ff;
	assign output_enable_n = oe_ff;
	assign program_strobe_n = pgm_ff;
	assign vcc_prog = vcc_ff;
	assign vpp_prog = vpp_ff;
	assign id_mode_address_line = id_mode_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Strobe low time in cycles, read by the pulse end check
	logic [12:0] low_cnt_ff, nxt_low_cnt;
	always_comb begin
		nxt_low_cnt = pgm_ff ? 13'h0 : low_cnt_ff + 13'h1;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_cnt_ff <= 13'h0;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
		end
	end

	sequence s_strobe_fall;
		$fell(program_strobe_n);
	endsequence
	sequence s_strobe_low;
		(!program_strobe_n) [*8];
	endsequence

	a_pulse_width: assert property (@(posedge clk_sys) disable iff (rst)
		s_strobe_fall |-> s_strobe_low)
		else $error("Strobe pulse too short");
	a_pulse_end: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(program_strobe_n) |-> low_cnt_ff == PULSE_CYC && low_cnt_ff >= PULSE_MIN_CYC
			&& low_cnt_ff <= PULSE_MAX_CYC)
		else $error("Strobe pulse width off");
	a_vpp_order: assert property (@(posedge clk_sys) disable iff (rst)
		vpp_prog |-> vcc_prog)
		else $error("Programming supply without core supply");
	a_pgm_levels: assert property (@(posedge clk_sys) disable iff (rst)
		!program_strobe_n |-> !chip_enable_n && output_enable_n && data_oe)
		else $error("Bad pin levels during pulse");
	a_bus_clash: assert property (@(posedge clk_sys) disable iff (rst)
		!output_enable_n |-> !data_oe)
		else $error("Host drives bus while output enabled");
	a_retry_cap: assert property (@(posedge clk_sys) disable iff (rst)
		try_ff <= `EPRG_MAX_RETRY)
		else $error("Too many extra pulses");
	a_final_supply: assert property (@(posedge clk_sys) disable iff (rst)
		ph_ff == PH_FINAL && st_ff == ST_OE |-> !vpp_prog && !vcc_prog)
		else $error("Final compare at programming supply");
	a_first_addr: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(vpp_prog) |-> addr == 16'h0)
		else $error("Pulsing not from first address");
	a_oe_wait: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(output_enable_n) && !id_mode_address_line |-> (output_enable_n == 1'b0) [*3])
		else $error("Read sampled too early");
	a_id_pins: assert property (@(posedge clk_sys) disable iff (rst)
		id_mode_address_line && !output_enable_n |-> addr[15:1] == 15'h0 && !vpp_prog)
		else $error("Bad identity read levels");
endmodule : eprg_host

// file: testbench/eprg_dev_model.sv
// Behavioural model of the 64K x 16 memory at the programmer pins
module eprg_dev_model #(
	parameter logic [15:0] MFR_CODE = 16'h005a, // Arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h00c3 // Arbitrary value
) (
	// Host-driven pins
	input wire logic [15:0] addr,
	input wire logic [15:0] din,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic strobe_n,
	input wire logic vcc_hi,
	input wire logic vpp_hi,
	input wire logic id_hi,
	// Device outputs
	output logic [15:0] q,
	output logic q_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:65535];
	logic [15:0] val;
	logic [15:0] hold;
	wire logic sel = !ce_n && !oe_n && (strobe_n || id_hi);

	// Erased cells read all ones
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;
		hold = 16'h0000;
	end
	// Stored word, or identity codes with upper byte zero
	assign val = id_hi ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr];
	// Valid 60 ns after the later enable, floats 30 ns after release
	assign #(60, 30) q_oe = sel;
	// Released lines show the inverse of the last word driven
	always @(q_oe or val) if (q_oe) hold = val;
	assign q = q_oe ? val : ~hold;
	// Strobe rising edge at programming level clears bits
	always @(posedge strobe_n) begin
		if (!ce_n && oe_n && vcc_hi && vpp_hi) mem[addr] = mem[addr] & din;
	end
endmodule : eprg_dev_model

// file: testbench/eprg_host_tb_top.sv
// Self-checking bench for the word programmer
module eprg_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] MFR_CODE = 16'h005a; // Arbitrary value
	localparam logic [15:0] DEV_CODE = 16'h00c3; // Arbitrary value
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic id_read = 1'b0;
	logic src_valid = 1'b0;
	logic [15:0] src_data = 16'h0000;
	logic busy, done, pass, src_ready, data_oe, chip_enable_n, output_enable_n;
	logic program_strobe_n, vcc_prog, vpp_prog, id_mode_address_line, q_oe;
	logic [15:0] id_code, addr, data_out, data_in, q;
	logic [15:0] src_q [$];
	int bad_count = 0;
	int checks_done = 0;
	int wid = 0;
	int pulses = 0;
	int exp_addr = 0;
	int k;
	logic oe_seen = 1'b0;
	logic order_bad = 1'b0;
	logic id_bad = 1'b0;

	// Clock and shared data lines
	always #25 clk_sys = ~clk_sys;
	assign data_in = data_oe ? data_out : q;

	eprg_host i_dut (.clk_sys(clk_sys), .rst(rst), .start(start), .id_read(id_read),
		.busy(busy), .done(done), .pass(pass), .id_code(id_code), .src_valid(src_valid),
		.src_ready(src_ready), .src_data(src_data), .addr(addr), .data_out(data_out),
		.data_oe(data_oe), .data_in(data_in), .chip_enable_n(chip_enable_n),
		.output_enable_n(output_enable_n), .program_strobe_n(program_strobe_n),
		.vcc_prog(vcc_prog), .vpp_prog(vpp_prog), .id_mode_address_line(id_mode_address_line));
	eprg_dev_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) i_dev (.addr(addr),
		.din(data_out), .ce_n(chip_enable_n), .oe_n(output_enable_n),
		.strobe_n(program_strobe_n), .vcc_hi(vcc_prog), .vpp_hi(vpp_prog),
		.id_hi(id_mode_address_line), .q(q), .q_oe(q_oe));

	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts it
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict
	task automatic stop_test();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// One cycle of a bounded wait
	task automatic guard(inout int n, input int lim);
		@(negedge clk_sys);
		n++;
		if (n > lim) begin
			bad_count++;
			stop_test();
		end
	endtask : guard
	// One-cycle command pulse, called at a rising edge
	task automatic kick(input logic is_id);
		#5;
		if (is_id) id_read = 1'b1;
		else start = 1'b1;
		@(posedge clk_sys);
		#5;
		id_read = 1'b0;
		start = 1'b0;
		@(posedge clk_sys);
	endtask : kick
	// Source word held until taken at a rising edge
	task automatic push(input logic [15:0] w);
		int n;
		n = 0;
		#5;
		src_data = w;
		src_valid = 1'b1;
		do guard(n, 90000); while (src_ready !== 1'b1);
		@(posedge clk_sys);
	endtask : push

	////////////////////////////////////////////////////////////////////////////////
	// Watches strobe pulses, supplies, enables and the identity line
	always @(negedge clk_sys) begin
		if (vpp_prog && !vcc_prog) order_bad <= 1'b1;
		if (vpp_prog && !output_enable_n) oe_seen <= 1'b1;
		if (id_mode_address_line && addr[15:1] != 15'h0) id_bad <= 1'b1;
		if (!program_strobe_n) begin
			if (wid == 0) begin
				check(addr, 16'(exp_addr));
				check(16'({vcc_prog, vpp_prog, chip_enable_n, output_enable_n}), 16'hd);
				exp_addr++;
			end
			wid++;
		end else if (wid != 0) begin
			check(16'(wid), 16'd2000);
			check(16'(wid * 50 >= 95000 && wid * 50 <= 105000), 16'h1);
			pulses++;
			wid = 0;
		end
	end

	// Main sequence
	initial begin
		void'($urandom(32'h40fb90b6));
		for (int i = 0; i < 40; i++) src_q.push_back(16'($urandom));
		repeat (3) @(posedge clk_sys);
		#5 rst = 1'b0;
		@(negedge clk_sys);
		check(16'({chip_enable_n, output_enable_n, program_strobe_n, vcc_prog, vpp_prog, busy,
			done, data_oe}), 16'he0);
		@(posedge clk_sys);
		kick(1'b1);
		k = 0;
		do guard(k, 5000); while (id_code === 16'h0000);
		check(id_code, MFR_CODE);
		do guard(k, 5000); while (done !== 1'b1);
		check(id_code, DEV_CODE);
		check(16'(id_bad), 16'h0);
		@(posedge clk_sys);
		kick(1'b0);
		repeat (4) @(negedge clk_sys);
		check(16'(busy), 16'h0);
		@(posedge clk_sys);
		for (int i = 0; i < 16; i++) push(src_q[i]);
		@(negedge clk_sys);
		check(16'(src_ready), 16'h0);
		@(posedge clk_sys);
		fork
			begin
				for (int i = 16; i < 40; i++) push(src_q[i]);
				#5 src_valid = 1'b0;
			end
		join_none
		kick(1'b0);
		k = 0;
		do guard(k, 30000); while (pulses < 8);
		check(16'(busy), 16'h1);
		@(posedge clk_sys);
		kick(1'b1);
		@(negedge clk_sys);
		check(16'(id_mode_address_line), 16'h0);
		for (int i = 0; i < 8; i++) check(i_dev.mem[i], src_q[i]);
		check(16'({oe_seen, order_bad}), 16'h0);
		@(posedge clk_sys);
		#5 rst = 1'b1;
		#5 check(16'({chip_enable_n, output_enable_n, program_strobe_n, vcc_prog, vpp_prog,
			busy, done, data_oe}), 16'he0);
		@(posedge clk_sys);
		#5 rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(16'({chip_enable_n, output_enable_n, program_strobe_n, vcc_prog, vpp_prog,
			busy, done, data_oe}), 16'he0);
		stop_test();
	end
endmodule : eprg_host_tb_top
